// ==== verilog/cs_region_cfg.svh ====
// Constants for the chip-select region and interface-type decoder
`ifndef CS_REGION_CFG_SVH
`define CS_REGION_CFG_SVH
`define PIN_ROLE_CE        2'h0
`define PIN_ROLE_WE        2'h1
`define PIN_ROLE_OE        2'h2
`define PIN_ROLE_ALT       2'h3
`define REGION_BOOT        3'h0
`define REGION_LAST        3'h5
`define INTERFACE_TYPE_FIELD_ASYNC_FAST   4'h0
`define INTERFACE_TYPE_FIELD_ASYNC_SLOW   4'h1
`define INTERFACE_TYPE_FIELD_SYNC_AOE     4'h2
`define INTERFACE_TYPE_FIELD_SYNC_SOE     4'h3
`define INTERFACE_TYPE_FIELD_BURST1_AOE   4'h5
`define INTERFACE_TYPE_FIELD_BURST1_SOE   4'h7
`define INTERFACE_TYPE_FIELD_BURST2       4'h8
`define INTERFACE_TYPE_FIELD_SYNC_EARLY   4'h9
`define BOOT_INTERFACE_TYPE_FIELD_RESET   4'h0
`define BOOT_WAIT_RESET    3'h7
`define MIN_SOE_WAIT       3'h1
`define NUM_REGIONS        6
`define NUM_PINS           12
`endif

// ==== verilog/cs_region_pkg.sv ====
// Types shared by the chip-select region decoder
`default_nettype none
package cs_region_pkg;
	typedef logic [3:0] interface_type_field_t;
	typedef logic [2:0] region_t;
	typedef logic [1:0] pin_role_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WAIT = 4'h2,
		ST_OE   = 4'h4,
		ST_DEAD = 4'h8
	} acc_state_e;
endpackage
`default_nettype wire

// ==== verilog/chip_select_region_interface_type_field.sv ====
// Chip-select pin role, region assignment and interface-type decoding
// How it works
// RQ1 - Two-bit role field picks pin function
// RQ2 - Region field matters only for WE/OE pins
// RQ3 - Region codes map boot plus one-five
// RQ4 - Reserved region code keeps pin idle
// RQ5 - Six regions each hold interface type
// RQ6 - Reserved interface type blocks chip select
// RQ7 - Only synchronous types are pipelineable
// RQ8 - Memory latches address when enabled
// RQ9 - Type zero: async, never pipelined
// RQ10 - Type one: dead clock between accesses
// RQ11 - Type two: sync, async output enable
// RQ12 - Early acknowledge still allows output enable
// RQ13 - Type three: one-cycle synchronous output enable
// RQ14 - Sync enable timed with at least one wait
// RQ15 - Type five: burst one, async enable
// RQ16 - Type seven: burst one, sync enable
// RQ17 - Burst memory holds beat until advance
// RQ18 - Boot region resets async, seven waits; the code takes boot waits from wait_states_i as for other regions
// RQ19 - Burst memories are synchronous ones
// RQ20 - Burst one ends by advance, two by last
`timescale 1ns/1ps
`default_nettype none
`include "cs_region_cfg.svh"
module chip_select_region_interface_type_field (
	input  wire logic        clk_i,               // System clock
	input  wire logic        rst_i,               // Synchronous reset, high
	input  wire logic [23:0] pin_role_field_i,    // Two role bits per pin
	input  wire logic [35:0] pin_region_i,        // Three region bits per pin
	input  wire logic [23:0] interface_type_field_i, // Four type bits, regions 1-5 at 4..23
	input  wire logic [3:0]  boot_interface_type_field_i,        // Boot type written by software
	input  wire logic        boot_interface_type_field_wr_i,     // Pulse: load boot type
	input  wire logic [2:0]  wait_states_i,       // Wait states of active region
	input  wire logic [5:0]  region_hit_i,        // Base-address match per region
	input  wire logic        access_start_i,      // Pulse: access begins
	input  wire logic        is_burst_i,          // Access is a burst
	input  wire logic        burst_end_i,         // Pulse: final beat requested
	input  wire logic        transfer_acknowledge_i, // Pulse: access acknowledged
	output logic [5:0]       region_enable_o,     // Chip-select enable per region
	output logic [11:0]      pin_assert_o,        // Per-pin assert, high active
	output logic [5:0]       pipelineable_o,      // Region may be pipelined
	output logic             output_enable_o,     // Output enable strobe
	output logic             burst_advance_control_o, // Burst type 1 end control
	output logic             burst_last_o,        // Burst type 2 last indication
	output logic             busy_o,              // Access in progress
	output logic [3:0]       boot_interface_type_field_o         // Boot region type
);
	// Region code, type validity and type class decoders
	function automatic logic region_valid(input cs_region_pkg::region_t r);
		region_valid = (r <= `REGION_LAST);
	endfunction
	function automatic logic interface_type_field_ok(input cs_region_pkg::interface_type_field_t t);
		interface_type_field_ok = (t <= `INTERFACE_TYPE_FIELD_SYNC_EARLY) && (t != 4'h4) && (t != 4'h6);
	endfunction
	function automatic logic interface_type_field_sync(input cs_region_pkg::interface_type_field_t t);
		interface_type_field_sync = interface_type_field_ok(t) && (t >= `INTERFACE_TYPE_FIELD_SYNC_AOE);
	endfunction

	cs_region_pkg::interface_type_field_t     boot_interface_type_field_q, boot_interface_type_field_d;
	cs_region_pkg::acc_state_e st_q, st_d;
	logic [2:0]                cnt_q, cnt_d;
	logic [2:0]                reg_q, reg_d;
	logic                      burst_q, burst_d;
	logic                      oe_q, oe_d;
	logic                      adv_q, adv_d;
	logic                      last_q, last_d;
	logic [5:0]                en_q, en_d;
	logic [11:0]               pin_q, pin_d;
	logic [5:0]                pipe_q, pipe_d;
	cs_region_pkg::interface_type_field_t     rtype [0:5];
	cs_region_pkg::interface_type_field_t     cur_t;
	logic                      cur_soe;
	logic [2:0]                hit_idx;
	logic                      hit_any;
	logic [5:0]                active;

	// Region type table, boot type held in a register
	assign rtype[0] = boot_interface_type_field_q; // RQ5
	genvar g;
	generate
		for (g = 1; g < `NUM_REGIONS; g++) begin : g_type
			assign rtype[g] = interface_type_field_i[4*g +: 4]; // RQ5
		end
	endgenerate

	// Select the hit region
	always_comb begin
		hit_idx = 3'h0;
		hit_any = 1'b0;
		for (int i = `NUM_REGIONS - 1; i >= 0; i--) begin
			if (region_hit_i[i] && interface_type_field_ok(rtype[i])) begin // RQ6
				hit_idx = 3'(i);
				hit_any = 1'b1;
			end
		end
		cur_t   = rtype[reg_q];
		cur_soe = (cur_t == `INTERFACE_TYPE_FIELD_SYNC_SOE) || (cur_t == `INTERFACE_TYPE_FIELD_BURST1_SOE)
			|| (cur_t == `INTERFACE_TYPE_FIELD_SYNC_EARLY);
	end

	// Access sequencer next state
	always_comb begin
		st_d    = st_q;
		cnt_d   = cnt_q;
		reg_d   = reg_q;
		burst_d = burst_q;
		oe_d    = 1'b0;
		adv_d   = adv_q;
		last_d  = 1'b0;
		case (st_q)
			cs_region_pkg::ST_IDLE: begin
				if (access_start_i && hit_any) begin
					reg_d   = hit_idx;
					burst_d = is_burst_i && (rtype[hit_idx] == `INTERFACE_TYPE_FIELD_BURST1_AOE
						|| rtype[hit_idx] == `INTERFACE_TYPE_FIELD_BURST1_SOE
						|| rtype[hit_idx] == `INTERFACE_TYPE_FIELD_BURST2);
					// Sync enable waits at least one state
					cnt_d   = (wait_states_i < `MIN_SOE_WAIT) ? `MIN_SOE_WAIT
						: wait_states_i; // RQ14
					adv_d   = is_burst_i && (rtype[hit_idx] == `INTERFACE_TYPE_FIELD_BURST1_AOE
						|| rtype[hit_idx] == `INTERFACE_TYPE_FIELD_BURST1_SOE);
					st_d    = cs_region_pkg::ST_WAIT;
				end
			end
			cs_region_pkg::ST_WAIT: begin
				if (cnt_q != 3'h0) begin
					cnt_d = cnt_q - 3'h1;
				end
				// Async enable holds through wait; early acknowledge does not block it
				if (!cur_soe && cur_t != `INTERFACE_TYPE_FIELD_BURST2) begin
					oe_d = 1'b1; // RQ11 RQ12 RQ15
				end
				if (cnt_q == 3'h1 || cnt_q == 3'h0) begin
					st_d = cs_region_pkg::ST_OE;
					oe_d = (cur_t != `INTERFACE_TYPE_FIELD_BURST2); // RQ13 RQ16 RQ18
				end
			end
			cs_region_pkg::ST_OE: begin
				if (!cur_soe && cur_t != `INTERFACE_TYPE_FIELD_BURST2) begin
					oe_d = !transfer_acknowledge_i || !burst_q; // RQ12
				end
				if (burst_q && cur_soe) begin
					oe_d = 1'b1;
				end
				if (burst_end_i && burst_q) begin
					adv_d  = 1'b0; // RQ20
					last_d = (cur_t == `INTERFACE_TYPE_FIELD_BURST2); // RQ20
				end
				if (transfer_acknowledge_i && (!burst_q || burst_end_i)) begin
					adv_d = 1'b0;
					oe_d  = 1'b0;
					st_d  = (cur_t == `INTERFACE_TYPE_FIELD_ASYNC_SLOW) ? cs_region_pkg::ST_DEAD
						: cs_region_pkg::ST_IDLE; // RQ10
				end
			end
			cs_region_pkg::ST_DEAD: begin
				st_d = cs_region_pkg::ST_IDLE; // RQ10
			end
			default: begin
				st_d = cs_region_pkg::ST_IDLE;
			end
		endcase
	end

	// Boot type next value
	always_comb begin
		boot_interface_type_field_d = boot_interface_type_field_wr_i ? boot_interface_type_field_i : boot_interface_type_field_q;
	end

	// Chip enables, pin roles and pipeline flags
	always_comb begin
		active = 6'h0;
		if (st_d != cs_region_pkg::ST_IDLE && st_d != cs_region_pkg::ST_DEAD) begin
			active[reg_d] = 1'b1;
		end
		for (int r = 0; r < `NUM_REGIONS; r++) begin
			en_d[r]   = active[r] && interface_type_field_ok(rtype[r]); // RQ6
			pipe_d[r] = interface_type_field_sync(rtype[r]); // RQ7 RQ9 RQ19
		end
		for (int p = 0; p < `NUM_PINS; p++) begin
			pin_d[p] = 1'b0;
			case (pin_role_field_i[2*p +: 2])
				`PIN_ROLE_CE: begin
					pin_d[p] = (p >= 1 && p <= 5) ? en_d[p] : 1'b0; // RQ1 RQ2
				end
				`PIN_ROLE_WE: begin
					if (region_valid(pin_region_i[3*p +: 3])) begin // RQ3 RQ4
						pin_d[p] = en_d[pin_region_i[3*p +: 3]]; // RQ1
					end
				end
				`PIN_ROLE_OE: begin
					if (region_valid(pin_region_i[3*p +: 3])) begin // RQ3 RQ4
						pin_d[p] = oe_d && active[pin_region_i[3*p +: 3]]; // RQ1
					end
				end
				default: begin
					pin_d[p] = 1'b0; // RQ1
				end
			endcase
		end
	end

	// Register all state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			boot_interface_type_field_q <= `BOOT_INTERFACE_TYPE_FIELD_RESET; // RQ18
			st_q         <= cs_region_pkg::ST_IDLE;
			cnt_q        <= 3'h0;
			reg_q        <= 3'h0;
			burst_q      <= 1'b0;
			oe_q         <= 1'b0;
			adv_q        <= 1'b0;
			last_q       <= 1'b0;
			en_q         <= 6'h0;
			pin_q        <= 12'h0;
			pipe_q       <= 6'h0;
		end else begin
			boot_interface_type_field_q <= boot_interface_type_field_d;
			st_q         <= st_d;
			cnt_q        <= cnt_d;
			reg_q        <= reg_d;
			burst_q      <= burst_d;
			oe_q         <= oe_d;
			adv_q        <= adv_d;
			last_q       <= last_d;
			en_q         <= en_d;
			pin_q        <= pin_d;
			pipe_q       <= pipe_d;
		end
	end

	// Outputs from registers
	assign region_enable_o         = en_q;
	assign pin_assert_o            = pin_q;
	assign pipelineable_o          = pipe_q;
	assign output_enable_o         = oe_q;
	assign burst_advance_control_o = adv_q;
	assign burst_last_o            = last_q;
	assign busy_o                  = (st_q != cs_region_pkg::ST_IDLE);
	assign boot_interface_type_field_o            = boot_interface_type_field_q;

	// Sequences used by the checks
	sequence s_slow_done;
		st_q == cs_region_pkg::ST_OE && transfer_acknowledge_i
			&& (!burst_q || burst_end_i) && cur_t == `INTERFACE_TYPE_FIELD_ASYNC_SLOW;
	endsequence
	sequence s_dead_then_idle;
		st_q == cs_region_pkg::ST_DEAD ##1 st_q == cs_region_pkg::ST_IDLE;
	endsequence

	// Boot select judged against the type it was decoded from
	reserved_type_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ6
		en_q[0] |-> $past(interface_type_field_ok(boot_interface_type_field_q))) else $error("enable on reserved type");
	dead_clock_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ10
		s_slow_done |=> s_dead_then_idle) else $error("no dead clock");
	pipe_sync_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ7
		pipe_q[0] |-> $past(boot_interface_type_field_q inside {`INTERFACE_TYPE_FIELD_SYNC_AOE, `INTERFACE_TYPE_FIELD_SYNC_SOE,
		`INTERFACE_TYPE_FIELD_BURST1_AOE, `INTERFACE_TYPE_FIELD_BURST1_SOE, `INTERFACE_TYPE_FIELD_BURST2, `INTERFACE_TYPE_FIELD_SYNC_EARLY}))
		else $error("async pipelined");
	type0_nopipe_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ9
		$past(boot_interface_type_field_q == `INTERFACE_TYPE_FIELD_ASYNC_FAST) |-> !pipe_q[0]) else $error("type0 piped");
	boot_reset_a: assert property (@(posedge clk_i) // RQ18
		$fell(rst_i) |-> boot_interface_type_field_q == `BOOT_INTERFACE_TYPE_FIELD_RESET && en_q == 6'h0)
		else $error("boot reset type");
	soe_one_wait_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ14
		st_q == cs_region_pkg::ST_IDLE ##1 st_q == cs_region_pkg::ST_WAIT
		|-> cnt_q != 3'h0) else $error("zero wait on start");
	reserved_pin_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ4
		(pin_role_field_i[1:0] == `PIN_ROLE_WE && !region_valid(pin_region_i[2:0]))
		|=> !pin_q[0]) else $error("reserved region pin asserted");
	burst_last_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ20
		burst_last_o |-> !burst_advance_control_o) else $error("last with advance");
	idle_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ13
		st_q == cs_region_pkg::ST_IDLE [*2] |-> !output_enable_o) else $error("oe idle");

	// Synchronous enable launched for a single access
	sequence s_soe_launch;
		$rose(output_enable_o) && cur_soe && !burst_q;
	endsequence
	// Burst finished by its acknowledge together with the end request
	sequence s_burst_close;
		st_q == cs_region_pkg::ST_OE && burst_q && burst_end_i && transfer_acknowledge_i;
	endsequence
	soe_one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ13
		s_soe_launch |=> !output_enable_o) else $error("sync oe too long");
	burst_adv_end_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ20
		s_burst_close |=> !burst_advance_control_o) else $error("advance after burst end");
	async_oe_wait_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ11 RQ15
		st_q == cs_region_pkg::ST_WAIT && !cur_soe && cur_t != `INTERFACE_TYPE_FIELD_BURST2
		|=> output_enable_o) else $error("async oe missing in wait");
	burst2_no_oe_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ20
		st_q != cs_region_pkg::ST_IDLE && cur_t == `INTERFACE_TYPE_FIELD_BURST2
		|=> !output_enable_o) else $error("oe on type 8 region");

	// Pins that cannot carry a chip enable stay quiet in that role
	genvar gp;
	generate
		for (gp = 0; gp < `NUM_PINS; gp++) begin : g_ce_chk
			if (gp == 0 || gp > 5) begin : g_limit
				ce_pin_limit_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ1
					pin_role_field_i[2*gp +: 2] == `PIN_ROLE_CE |=> !pin_q[gp])
					else $error("chip enable on a non-enable pin");
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ==== bench/mem_partner.sv ====
// Memory model that acknowledges each enabled access
`timescale 1ns/1ps
`default_nettype none
module mem_partner (
	input  wire logic       clk_i,  // System clock
	input  wire logic [5:0] en_i,   // Region chip selects
	input  wire logic [2:0] wait_i, // Wait states of the region
	input  wire logic       slow_i, // Answer two cycles later
	output logic            ack_o   // Acknowledge pulse
);
	logic [3:0] cnt = 4'h0;
	logic       ack_q = 1'b0;
	// Address is taken as the select rises, so only the count matters
	always @(negedge clk_i) begin
		cnt <= (en_i != 6'h0) ? cnt + 4'h1 : 4'h0;
	end
	// First beat stays valid until acknowledged, one pulse per access
	always @(negedge clk_i) begin
		ack_q <= (en_i != 6'h0) && (cnt == {1'b0, wait_i} + (slow_i ? 4'h4 : 4'h2));
	end
	// Acknowledge straight from its flop
	assign ack_o = ack_q;
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the region and interface-type decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [23:0] role = 24'h0;
	logic [35:0] rmap = 36'h0;
	logic [23:0] interface_type_field = 24'h0;
	logic [3:0]  boot_t = 4'h0;
	logic        boot_wr = 1'b0;
	logic [2:0]  waits = 3'h0;
	logic [5:0]  hit = 6'h0;
	logic        start = 1'b0;
	logic        burst = 1'b0;
	logic        bend = 1'b0;
	logic        slow = 1'b0;
	logic        ack;
	logic [5:0]  en;
	logic [5:0]  pipe;
	logic [11:0] pins;
	logic [11:0] pin_seen;
	logic        oe;
	logic        adv;
	logic        last;
	logic        busy;
	logic [3:0]  boot_o;
	logic [2:0]  flags;
	logic        busy_seen;
	int          errors = 0;
	int          num_checks = 0;
	int          oe_cnt;
	int          g0;
	int          g1;
	chip_select_region_interface_type_field dut (.clk_i(clk_i), .rst_i(rst_i), .pin_role_field_i(role),
		.pin_region_i(rmap), .interface_type_field_i(interface_type_field), .boot_interface_type_field_i(boot_t),
		.boot_interface_type_field_wr_i(boot_wr), .wait_states_i(waits), .region_hit_i(hit),
		.access_start_i(start), .is_burst_i(burst), .burst_end_i(bend),
		.transfer_acknowledge_i(ack), .region_enable_o(en), .pin_assert_o(pins),
		.pipelineable_o(pipe), .output_enable_o(oe), .burst_advance_control_o(adv),
		.burst_last_o(last), .busy_o(busy), .boot_interface_type_field_o(boot_o));
	mem_partner mem (.clk_i(clk_i), .en_i(en), .wait_i(waits), .slow_i(slow), .ack_o(ack));
	// Clock at 100 MHz
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic end_sim();
		$display("errors %0d, checks %0d", errors, num_checks);
		if (errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// One access to region r, recording what the outputs did
	task automatic access(input int r, input logic [3:0] t, input logic [2:0] w, input logic b);
		interface_type_field[4*r +: 4] = t;
		hit = 6'h1 << r;
		waits = w;
		burst = b;
		@(negedge clk_i);
		start = 1'b1;
		@(negedge clk_i);
		start = 1'b0;
		oe_cnt = 0;
		pin_seen = 12'h0;
		flags = 3'h0;
		busy_seen = 1'b0;
		for (int i = 0; i < 30; i++) begin
			oe_cnt += int'(oe);
			pin_seen |= pins;
			flags |= {adv, last, en[r]};
			busy_seen |= busy;
			// End request meets the partner's acknowledge edge
			bend = b && (i == int'(w) + 2);
			@(negedge clk_i);
		end
	endtask
	// Idle cycles between two accesses while a start is held up
	task automatic gap_of(input logic [3:0] t, output int g);
		int ph;
		ph = 0;
		g = 0;
		interface_type_field[11:8] = t;
		hit = 6'h04;
		burst = 1'b0;
		start = 1'b1;
		for (int i = 0; i < 40; i++) begin
			@(negedge clk_i);
			if (ph == 0 && en[2])
				ph = 1;
			else if (ph == 1 && !en[2])
				ph = 2;
			if (ph == 2 && en[2])
				ph = 3;
			else if (ph == 2)
				g++;
		end
		start = 1'b0;
		@(negedge clk_i);
	endtask
	task automatic t_pipe();
		for (int c = 0; c < 16; c++) begin
			interface_type_field[7:4] = c[3:0];
			repeat (2) @(negedge clk_i);
			chk("pipe", 12'(c inside {2, 3, 5, 7, 8, 9}), 12'(pipe[1]));
		end
	endtask
	task automatic t_reserved();
		logic [3:0] codes [8] = '{4'h4, 4'h6, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
		foreach (codes[k]) begin
			access(1, codes[k], 3'h1, 1'b0);
			chk("reserved en", 12'h0, 12'(flags[0]));
			chk("reserved busy", 12'h0, 12'(busy_seen));
		end
	endtask
	task automatic t_pins();
		// Pin 0 WE to a reserved region, 1 CE, 2 OE and 3 WE of region 1,
		// 4 OE of region 4, 5 alternate, 6 CE, 7 WE to a reserved region
		role = 24'h004e61;
		rmap = 36'h000e4c27e;
		access(1, 4'h3, 3'h0, 1'b0);
		chk("pins", 12'h00e, pin_seen);
		chk("soe count", 12'h1, 12'(oe_cnt));
	endtask
	task automatic t_types();
		logic [3:0] ty [4] = '{4'h2, 4'h5, 4'h7, 4'h8};
		logic [2:0] fx [4] = '{3'b001, 3'b101, 3'b101, 3'b011};
		foreach (ty[k]) begin
			access(3, ty[k], 3'h2, k != 0);
			chk("flags", 12'(fx[k]), 12'(flags));
			chk("oe", 12'(k != 3), 12'(oe_cnt != 0));
		end
	endtask
	task automatic t_dead();
		slow = 1'b1;
		gap_of(4'h0, g0);
		gap_of(4'h1, g1);
		slow = 1'b0;
		chk("dead gap", 12'(g0 + 1), 12'(g1));
	endtask
	task automatic t_boot();
		chk("boot reset", 12'h0, 12'(boot_o));
		boot_t = 4'h7;
		boot_wr = 1'b1;
		@(negedge clk_i);
		boot_wr = 1'b0;
		@(negedge clk_i);
		chk("boot type", 12'h7, 12'(boot_o));
		access(0, 4'h0, 3'h7, 1'b0);
		chk("boot en", 12'h1, 12'(flags[0]));
		chk("boot busy", 12'h1, 12'(busy_seen));
		chk("boot oe", 12'h1, 12'(oe_cnt != 0));
	endtask
	// Reset, then the scenarios
	initial begin
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		chk("en reset", 12'h0, 12'(en));
		t_boot();
		t_pipe();
		t_reserved();
		t_pins();
		t_types();
		t_dead();
		end_sim();
	end
	// Watchdog well beyond the expected run
	initial begin
		#50us;
		errors++;
		end_sim();
	end
endmodule
`default_nettype wire
